// [sbbr_dev_model.sv]
// Behavioural model of the paged flash in burst block read mode.
// Assumes the host controller drives its pins; page loads take a set delay.
`timescale 1ns/1ps
module sbbr_dev_model (
    // Host pins
    input wire logic i_fl_clk,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_adv_n,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_dq,
    // Scenario controls
    input wire logic i_slow,
    input wire logic i_no_rdy,
    // Device pins
    output logic [15:0] o_dq,
    output logic o_rdy,
    output logic o_int,
    // Host misbehaviour seen
    output logic [15:0] o_errs
);
    import sbbr_pkg::*;
    logic [15:0] dev_r [0:5];
    logic [2:0] lat_r = LAT_RST;
    logic active = 1'b0;
    logic [5:0] pg = 6'h00;
    logic [6:0] left = 7'h00;
    int rc = 0;
    int nw = 0;
    initial begin
        o_dq = 16'h0000;
        o_rdy = 1'b0;
        o_int = 1'b1;
        o_errs = 16'h0000;
    end
    // Register writes taken as write enable falls
    always @(negedge i_we_n) begin
        if (active) o_errs++;
        if (i_addr >= DEV_SYSCFG && i_addr <= DEV_CMD) dev_r[i_addr - DEV_SYSCFG] = i_dq;
        if (i_addr == DEV_SYSCFG) lat_r = i_dq[CFG_LAT_POS+:3];
        if (i_addr == DEV_CMD && i_dq == CMD_BLOCK_READ) begin
            pg = dev_r[1][5:0];
            left = dev_r[1][14:8];
            if (dev_r[0][CFG_INT_AUTO] !== 1'b1) o_errs++;
            if (dev_r[2] !== BUF_SETUP || dev_r[3] !== 16'h0000) o_errs++;
            if (left < 7'h03 || left > 7'h40 || int'(pg) + int'(left) > 64) o_errs++;
            active = 1'b1;
            o_int = 1'b0;
            #(i_slow ? 20000 : 400) o_int = 1'b1;
        end
    end
    always @(negedge i_ce_n) begin
        if (active && !o_int) o_errs++;
        rc = 0;
        nw = 0;
    end
    always @(posedge i_fl_clk) begin
        if (!i_ce_n && (rc > 0 || !i_adv_n)) begin
            if (rc == 0 && i_addr[1:0] != 2'b00) o_errs++;
            rc++;
        end
    end
    // Words change mid-cycle so each is stable around its fetch rise
    always @(negedge i_fl_clk) begin
        if (!i_ce_n && rc > 0) begin
            if (rc == lat_r && !i_no_rdy) o_rdy = 1'b1;
            if (rc > lat_r && nw < 1024) begin
                o_dq = {pg, nw[9:0]};
                nw++;
            end
        end
    end
    always @(posedge i_ce_n) begin
        o_rdy = 1'b0;
        o_dq = ~o_dq;
        if (active && nw == 1024) begin
            o_int = 1'b0;
            pg++;
            left--;
            if (left == 7'h00) active = 1'b0;
            else #(i_slow ? 20000 : 400) o_int = 1'b1;
        end
    end
endmodule // sbbr_dev_model

// [sbbr_host.sv]
// Host controller for burst block read of a paged flash.
// Assumes the device sits on the fl pins and software on the plain port.
//
// Contract
// - Page count is three to sixty-four
// - Start plus count stays inside block
// - Buffer word addresses are multiples of four
// - Assert chip enable after indicator rises
// - Enable automatic indicator mode before start
// - Write enable stays high throughout
// - Chip enable high while indicator low
// - Latency chosen by flash clock rate
// - First data on edge latency plus one
// - Buffer sector setup before command
`timescale 1ns/1ps
module sbbr_host (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Software port
    input wire logic [sbbr_pkg::SW_AW-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Page word stream
    output logic [15:0] o_word,
    output logic o_word_valid,
    output logic o_busy,
    // Flash pins
    output logic o_fl_clk,
    output logic o_fl_ce_n,
    output logic o_fl_oe_n,
    output logic o_fl_we_n,
    output logic o_fl_address_valid_n,
    output logic [15:0] o_fl_addr,
    output logic [15:0] o_fl_dq,
    output logic o_fl_dq_oe,
    input wire logic [15:0] i_fl_dq,
    input wire logic i_fl_rdy,
    input wire logic i_fl_int
);
    import sbbr_pkg::*;

    sbbr_pin_if pin ();

    sbbr_pin_front u_front (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_fl_rdy(i_fl_rdy),
        .i_fl_int(i_fl_int),
        .i_fl_dq(i_fl_dq),
        .pin(pin)
    );

    sbbr_state_t st_r;
    sbbr_state_t st_nxt;
    logic [5:0] start_r;
    logic [6:0] count_r;
    logic [2:0] lat_r;
    logic [6:0] pages_r;
    logic [2:0] step_r;
    logic [3:0] tcnt_r;
    logic [3:0] lat_cnt_r;
    logic [10:0] wcnt_r;
    logic refused_r;
    logic no_rdy_r;
    logic done_r;
    logic ce_n_r;
    logic oe_n_r;
    logic we_n_r;
    logic adv_n_r;
    logic [15:0] addr_r;
    logic [15:0] dq_r;
    logic dq_oe_r;
    logic run_r;
    logic [15:0] word_r;
    logic wv_r;
    logic busy_r;
    logic [15:0] rdata_r;

    // Device register write for each setup step
    function automatic logic [31:0] dev_step(input logic [2:0] idx,
                                             input logic [5:0] start,
                                             input logic [6:0] count,
                                             input logic [2:0] lat);
        logic [15:0] cfg;
        logic [15:0] pg;
        cfg = 16'h0;
        cfg[CFG_SYNC_RD] = 1'b1;
        cfg[CFG_INT_AUTO] = 1'b1;
        cfg[CFG_LAT_POS +: 3] = lat;
        pg = 16'h0;
        pg[5:0] = start;
        pg[PG_COUNT_POS +: 7] = count;
        unique case (idx)
            3'h0: dev_step = {DEV_SYSCFG, cfg};
            3'h1: dev_step = {DEV_PAGE, pg};
            3'h2: dev_step = {DEV_BUF, BUF_SETUP};
            3'h3: dev_step = {DEV_SECT, 16'h0000};
            3'h4: dev_step = {DEV_INT, 16'h0000};
            default: dev_step = {DEV_CMD, CMD_BLOCK_READ};
        endcase
    endfunction

    // Software decode
    wire idle = st_r == S_IDLE;
    wire wr_start = i_wr && i_addr == REG_START && idle;
    wire wr_count = i_wr && i_addr == REG_COUNT && idle;
    wire wr_lat = i_wr && i_addr == REG_LAT && idle;
    wire wr_stat = i_wr && i_addr == REG_STAT;
    wire go_req = i_wr && i_addr == REG_CTRL && i_wdata[CTRL_GO];
    wire [7:0] end_page = {2'h0, start_r} + {1'h0, count_r};
    wire cnt_ok = count_r >= PAGES_MIN && count_r <= PAGES_MAX;
    wire span_ok = end_page <= PAGES_PER_BLOCK;
    wire lat_ok = lat_r >= LAT_MIN;
    wire go_ok = go_req && idle && cnt_ok && span_ok && lat_ok;
    wire go_bad = go_req && !go_ok;

    // Sequencer decode
    wire [31:0] step_w = dev_step(step_r, start_r, count_r, lat_r);
    wire last_step = step_r == SETUP_LAST;
    wire we_done = tcnt_r == 4'(WE_LOW_CYC - 1);
    wire samp = pin.samp;
    wire first_edge = st_r == S_LAT && samp && lat_cnt_r == {1'b0, lat_r};
    wire rdy_edge = st_r == S_LAT && samp && lat_cnt_r == {1'b0, lat_r} - 4'h1;
    wire burst_edge = st_r == S_BURST && samp;
    wire page_end = burst_edge && wcnt_r == PAGE_LAST;
    wire last_page = 7'(pages_r + 7'h01) == count_r;
    wire take_word = first_edge || burst_edge;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            S_IDLE: if (go_ok) st_nxt = S_WR_SET;
            S_WR_SET: st_nxt = S_WR_PULSE;
            S_WR_PULSE: if (we_done) st_nxt = S_WR_END;
            S_WR_END: st_nxt = last_step ? S_WAIT_LO : S_WR_SET;
            // Chip enable stays high until indicator has fallen and risen again
            S_WAIT_LO: if (!pin.int_s) st_nxt = S_WAIT_HI;
            // Page begins only on low to high of indicator
            S_WAIT_HI: if (pin.int_s) st_nxt = S_ADDR;
            S_ADDR: if (samp) st_nxt = S_LAT;
            S_LAT: if (first_edge) st_nxt = S_BURST;
            S_BURST: if (page_end) st_nxt = last_page ? S_IDLE : S_WAIT_LO;
        endcase
    end

    // Pin levels chosen from the next state
    wire ce_nxt = st_nxt inside {S_WR_SET, S_WR_PULSE, S_ADDR, S_LAT, S_BURST};
    wire adv_nxt = st_nxt inside {S_WR_SET, S_WR_PULSE, S_ADDR};
    wire we_nxt = st_nxt == S_WR_PULSE;
    wire oe_nxt = st_nxt inside {S_ADDR, S_LAT, S_BURST};
    wire run_nxt = st_nxt inside {S_ADDR, S_LAT, S_BURST};
    wire drv_nxt = st_nxt inside {S_WR_SET, S_WR_PULSE, S_WR_END};
    // Setup always opens at the first step, whatever the last job left behind
    wire [2:0] step_nxt = st_r == S_IDLE ? 3'h0 :
                          st_r == S_WR_END ? 3'(step_r + 3'h1) : step_r;
    wire [31:0] wr_nxt = dev_step(step_nxt, start_r, count_r, lat_r);
    wire [15:0] addr_nxt = drv_nxt ? wr_nxt[31:16] : DEV_BUF_BASE;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= S_IDLE;
            ce_n_r <= 1'b1;
            adv_n_r <= 1'b1;
            we_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            run_r <= 1'b0;
            dq_oe_r <= 1'b0;
            addr_r <= 16'h0;
            dq_r <= 16'h0;
            busy_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ce_n_r <= !ce_nxt;
            adv_n_r <= !adv_nxt;
            we_n_r <= !we_nxt;
            oe_n_r <= !oe_nxt;
            run_r <= run_nxt;
            dq_oe_r <= drv_nxt;
            addr_r <= addr_nxt;
            dq_r <= drv_nxt ? wr_nxt[15:0] : 16'h0;
            busy_r <= st_nxt != S_IDLE;
        end
    end

    // Setup step and strobe width counters
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_r <= 3'h0;
            tcnt_r <= 4'h0;
        end else begin
            if (go_ok) step_r <= 3'h0;
            else if (st_r == S_WR_END && !last_step) step_r <= step_r + 3'h1;
            tcnt_r <= (st_r == S_WR_PULSE && !we_done) ? tcnt_r + 4'h1 : 4'h0;
        end
    end

    // Latency, word and page counters
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_cnt_r <= 4'h0;
            wcnt_r <= 11'h0;
            pages_r <= 7'h0;
        end else begin
            if (st_r != S_LAT) lat_cnt_r <= 4'h0;
            else if (samp) lat_cnt_r <= lat_cnt_r + 4'h1;
            if (first_edge) wcnt_r <= 11'h1;
            else if (burst_edge) wcnt_r <= wcnt_r + 11'h1;
            if (go_ok) pages_r <= 7'h0;
            else if (page_end) pages_r <= pages_r + 7'h1;
        end
    end

    // Captured words leave as one-cycle strobes
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_r <= 16'h0;
            wv_r <= 1'b0;
        end else begin
            wv_r <= take_word;
            if (take_word) word_r <= pin.dq_s;
        end
    end

    // Software registers, sticky flags with set winning over clear
    wire stat_clr_ref = wr_stat && i_wdata[ST_REFUSED];
    wire stat_clr_rdy = wr_stat && i_wdata[ST_NO_RDY];
    wire stat_clr_done = wr_stat && i_wdata[ST_DONE];
    wire rdy_miss = rdy_edge && !pin.rdy_s;
    wire job_done = page_end && last_page;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_r <= 6'h0;
            count_r <= PAGES_MIN;
            lat_r <= LAT_RST;
            refused_r <= 1'b0;
            no_rdy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (wr_start) start_r <= i_wdata[5:0];
            if (wr_count) count_r <= i_wdata[6:0];
            if (wr_lat) lat_r <= i_wdata[2:0];
            refused_r <= go_bad || (refused_r && !stat_clr_ref);
            no_rdy_r <= rdy_miss || (no_rdy_r && !stat_clr_rdy);
            done_r <= job_done || (done_r && !stat_clr_done);
        end
    end

    wire [15:0] stat_w = {12'h0, done_r, no_rdy_r, refused_r, busy_r};
    wire [15:0] rd_mux = i_addr == REG_START ? {10'h0, start_r} :
                         i_addr == REG_COUNT ? {9'h0, count_r} :
                         i_addr == REG_LAT ? {13'h0, lat_r} :
                         i_addr == REG_STAT ? stat_w :
                         i_addr == REG_PAGES ? {9'h0, pages_r} : 16'h0;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) rdata_r <= 16'h0;
        else rdata_r <= i_rd ? rd_mux : 16'h0;
    end

    assign pin.run = run_r;
    assign o_rdata = rdata_r;
    assign o_word = word_r;
    assign o_word_valid = wv_r;
    assign o_busy = busy_r;
    assign o_fl_clk = pin.fclk;
    assign o_fl_ce_n = ce_n_r;
    assign o_fl_oe_n = oe_n_r;
    assign o_fl_we_n = we_n_r;
    assign o_fl_address_valid_n = adv_n_r;
    assign o_fl_addr = addr_r;
    assign o_fl_dq = dq_r;
    assign o_fl_dq_oe = dq_oe_r;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    AST_WE_HIGH_READ:
        assert property (st_r inside {S_WAIT_LO, S_WAIT_HI, S_ADDR, S_LAT, S_BURST}
                         |-> we_n_r)
        else $error("write enable low during block read");
    AST_CE_HIGH_INT_LO:
        assert property (st_r == S_WAIT_HI && !pin.int_s |-> ce_n_r && !run_r)
        else $error("chip enable low while indicator low");
    AST_CE_AFTER_RISE:
        assert property (st_r == S_WAIT_HI && pin.int_s |=> !ce_n_r && !adv_n_r
                         ##1 st_r == S_ADDR)
        else $error("page not opened after indicator rise");
    AST_ALIGN4:
        assert property (!adv_n_r && !oe_n_r |-> addr_r[1:0] == 2'h0 && we_n_r)
        else $error("buffer address not a multiple of four");
    AST_COUNT_RANGE:
        assert property ($rose(busy_r) |-> count_r >= PAGES_MIN && count_r <= PAGES_MAX
                         && end_page <= PAGES_PER_BLOCK)
        else $error("page count or span illegal at start");
    AST_LAT_MIN:
        assert property ($rose(busy_r) |-> lat_r >= LAT_MIN && $past(go_ok))
        else $error("latency too low for flash clock");
    AST_INT_AUTO:
        assert property (st_r == S_WR_PULSE && addr_r == DEV_SYSCFG
                         |-> dq_r[CFG_INT_AUTO] && dq_oe_r && !we_n_r)
        else $error("indicator auto mode not enabled");
    AST_BUF_SETUP:
        assert property (st_r == S_WR_SET && step_r == 3'h2 |-> addr_r == DEV_BUF
                         && dq_r == BUF_SETUP ##1 !we_n_r)
        else $error("buffer sector setup wrong");
    AST_FIRST_WORD:
        assert property ($rose(st_r == S_LAT) ##0 (!samp throughout ##1 1'b1)
                         |-> !wv_r[*2])
        else $error("word taken before latency elapsed");
    AST_PAGE_STEP:
        assert property (page_end && !last_page |=> st_r == S_WAIT_LO && ce_n_r
                         && pages_r == $past(pages_r) + 7'h1)
        else $error("page counter did not advance");
    AST_CE_WAIT_LO:
        assert property (st_r == S_WAIT_LO |-> ce_n_r && oe_n_r && !run_r)
        else $error("chip enable low while waiting for indicator");
    AST_FIRST_SETUP:
        assert property (st_r == S_WR_SET && $past(st_r) == S_IDLE
                         |-> addr_r == DEV_SYSCFG && dq_r[CFG_INT_AUTO])
        else $error("setup did not open with configuration write");
    AST_CMD_LAST:
        assert property (st_r == S_WR_PULSE && step_r == SETUP_LAST
                         |-> addr_r == DEV_CMD && dq_r == CMD_BLOCK_READ)
        else $error("block read command not last setup write");
    AST_DONE_FLAG:
        assert property (job_done |=> done_r && !busy_r && st_r == S_IDLE)
        else $error("job end not reported");
endmodule // sbbr_host

// [sbbr_pin_front.sv]
// Flash clock divider and input synchronisers.
// Assumes flash pins are asynchronous to the core clock.
`timescale 1ns/1ps
module sbbr_pin_front (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Raw pins
    input wire logic i_fl_rdy,
    input wire logic i_fl_int,
    input wire logic [15:0] i_fl_dq,
    // Sequencer side
    sbbr_pin_if.front pin
);
    import sbbr_pkg::*;
    logic [3:0] div_r;
    logic rise_r;
    logic [1:0] samp_r;
    logic [17:0] meta_r;
    wire half_end = div_r == 4'(DIV_HALF - 1);

    // Free divider while running, parked low otherwise
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= 4'h0;
            pin.fclk <= 1'b0;
        end else if (!pin.run) begin
            div_r <= 4'h0;
            pin.fclk <= 1'b0;
        end else if (half_end) begin
            div_r <= 4'h0;
            pin.fclk <= ~pin.fclk;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    // Sample strike lines up with the synchroniser delay
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_r <= 1'b0;
            samp_r <= 2'h0;
        end else begin
            rise_r <= pin.run && half_end && !pin.fclk;
            samp_r <= {samp_r[0], rise_r};
        end
    end
    assign pin.samp = samp_r[1];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= 18'h0;
            pin.rdy_s <= 1'b0;
            pin.int_s <= 1'b0;
            pin.dq_s <= 16'h0;
        end else begin
            meta_r <= {i_fl_rdy, i_fl_int, i_fl_dq};
            {pin.rdy_s, pin.int_s, pin.dq_s} <= meta_r;
        end
    end
endmodule // sbbr_pin_front

// [sbbr_pin_if.sv]
// Carrier between the pin front end and the sequencer.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface sbbr_pin_if;
    logic run;
    logic fclk;
    logic samp;
    logic rdy_s;
    logic int_s;
    logic [15:0] dq_s;
    modport front (input run, output fclk, samp, rdy_s, int_s, dq_s);
    modport core (output run, input fclk, samp, rdy_s, int_s, dq_s);
endinterface

// [sbbr_pkg.sv]
// Constants for the burst block read host controller.
// Assumes a 125 MHz core clock; device register addresses are local choices.
package sbbr_pkg;
    // Core clock
    localparam int CLK_MHZ = 125;
    localparam int CLK_PERIOD_PS = 8000;
    // Write strobe low time, rounded up to whole cycles
    localparam int T_WE_LOW_NS = 40;
    localparam int WE_LOW_CYC = (T_WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Flash clock: core cycles per half period
    localparam int DIV_HALF = 2;
    localparam int FLASH_KHZ = CLK_MHZ * 1000 / (2 * DIV_HALF);
    // Latency limits, lowest legal one follows the flash clock rate
    localparam logic [2:0] LAT_MIN = (FLASH_KHZ <= 40000) ? 3'h3 :
                                     (FLASH_KHZ <= 66000) ? 3'h5 : 3'h6;
    localparam logic [2:0] LAT_RST = 3'h4;
    // Page limits
    localparam logic [6:0] PAGES_MIN = 7'h03;
    localparam logic [6:0] PAGES_MAX = 7'h40;
    localparam logic [7:0] PAGES_PER_BLOCK = 8'h40;
    localparam logic [10:0] PAGE_LAST = 11'h3FF;
    // Software register indices
    localparam int SW_AW = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_START = 3'h1;
    localparam logic [2:0] REG_COUNT = 3'h2;
    localparam logic [2:0] REG_LAT = 3'h3;
    localparam logic [2:0] REG_STAT = 3'h4;
    localparam logic [2:0] REG_PAGES = 3'h5;
    localparam int CTRL_GO = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_NO_RDY = 2;
    localparam int ST_DONE = 3;
    // Device register addresses and field values
    localparam logic [15:0] DEV_SYSCFG = 16'hF100;
    localparam logic [15:0] DEV_PAGE = 16'hF101;
    localparam logic [15:0] DEV_BUF = 16'hF102;
    localparam logic [15:0] DEV_SECT = 16'hF103;
    localparam logic [15:0] DEV_INT = 16'hF104;
    localparam logic [15:0] DEV_CMD = 16'hF105;
    localparam logic [15:0] DEV_BUF_BASE = 16'h0200;
    localparam int CFG_SYNC_RD = 15;
    localparam int CFG_LAT_POS = 12;
    localparam int CFG_INT_AUTO = 5;
    localparam int PG_COUNT_POS = 8;
    localparam logic [15:0] BUF_SETUP = 16'h0800;
    localparam logic [15:0] CMD_BLOCK_READ = 16'h00A0;
    localparam logic [2:0] SETUP_LAST = 3'h5;
    typedef enum logic [3:0] {
        S_IDLE, S_WR_SET, S_WR_PULSE, S_WR_END, S_WAIT_LO, S_WAIT_HI,
        S_ADDR, S_LAT, S_BURST
    } sbbr_state_t;
endpackage

// [tb.sv]
// Self-checking bench for the burst block read host controller.
// Assumes the package, design files and device model are compiled first.
`timescale 1ns/1ps
module tb;
    import sbbr_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [SW_AW-1:0] i_addr = '0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic slow = 1'b0;
    logic no_rdy = 1'b0;
    logic rd_q = 1'b0;
    logic [15:0] o_rdata, o_word, fl_addr, fl_dq, fl_dq_in, dev_dq, dev_errs;
    logic o_word_valid, o_busy, fl_clk, fl_ce_n, fl_oe_n, fl_we_n, fl_adv_n;
    logic fl_dq_oe, fl_rdy, fl_int;
    logic [15:0] exp_rd[$];
    logic [15:0] exp_wd[$];
    logic [15:0] rst_vals [1:7] = '{16'h0000, 16'h0003, 16'h0004, 16'h0000,
                                    16'h0000, 16'h0000, 16'h0000};
    int failures = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'hE704AEA8;
    always #4 i_core_clk = ~i_core_clk;
    assign fl_dq_in = fl_dq_oe ? fl_dq : dev_dq;
    sbbr_host i_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_word(o_word),
        .o_word_valid(o_word_valid), .o_busy(o_busy), .o_fl_clk(fl_clk), .o_fl_ce_n(fl_ce_n),
        .o_fl_oe_n(fl_oe_n), .o_fl_we_n(fl_we_n), .o_fl_address_valid_n(fl_adv_n),
        .o_fl_addr(fl_addr), .o_fl_dq(fl_dq), .o_fl_dq_oe(fl_dq_oe), .i_fl_dq(fl_dq_in),
        .i_fl_rdy(fl_rdy), .i_fl_int(fl_int)
    );
    sbbr_dev_model i_dev (
        .i_fl_clk(fl_clk), .i_ce_n(fl_ce_n), .i_we_n(fl_we_n), .i_adv_n(fl_adv_n),
        .i_addr(fl_addr), .i_dq(fl_dq_in), .i_slow(slow), .i_no_rdy(no_rdy),
        .o_dq(dev_dq), .o_rdy(fl_rdy), .o_int(fl_int), .o_errs(dev_errs)
    );
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One software access per cycle; a read notes its expected data
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
        if (r) exp_rd.push_back(d);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] d);
        bus(1'b0, 1'b1, a, d);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Status 16'h0002 means the start is expected to be refused
    task automatic job(input logic [5:0] st, input logic [6:0] cnt, input logic [2:0] lat,
                       input logic [15:0] stat);
        int i;
        logic ok;
        ok = (stat != 16'h0002);
        wr(REG_START, {10'h000, st});
        wr(REG_COUNT, {9'h000, cnt});
        wr(REG_LAT, {13'h0000, lat});
        for (i = 0; ok && i < cnt * 1024; i++) exp_wd.push_back({st + 6'(i / 1024), 10'(i)});
        wr(REG_CTRL, 16'h0001);
        wr(REG_CTRL, 16'h0001);
        wr(REG_START, {10'h000, ~st});
        rd(REG_STAT, ok ? 16'h0003 : 16'h0002);
        rd(REG_LAT, {13'h0000, lat});
        bus(1'b0, 1'b0, REG_CTRL, 16'h0000);
        for (i = 0; i < 80000 && o_busy !== 1'b0; i++) @(posedge i_core_clk);
        check({15'h0000, o_busy}, 16'h0000);
        rd(REG_STAT, stat);
        rd(REG_START, {10'h000, ok ? st : ~st});
        if (ok) rd(REG_PAGES, {9'h000, cnt});
        wr(REG_STAT, 16'h000E);
        rd(REG_STAT, 16'h0000);
        bus(1'b0, 1'b0, REG_CTRL, 16'h0000);
        check(16'(exp_wd.size()), 16'h0000);
        check(dev_errs, 16'h0000);
        $display("job start %0d count %0d latency %0d done", st, cnt, lat);
    endtask
    // Results are compared in the order they were noted
    always @(posedge i_core_clk) begin
        if (rd_q) check(o_rdata, exp_rd.size() ? exp_rd.pop_front() : ~o_rdata);
        if (o_word_valid === 1'b1) check(o_word, exp_wd.size() ? exp_wd.pop_front() : ~o_word);
        rd_q <= i_rd;
    end
    initial begin
        int a;
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        for (a = 1; a < 8; a++) rd(3'(a), rst_vals[a]);
        bus(1'b0, 1'b0, REG_CTRL, 16'h0000);
        $display("register reset values done");
        job(6'h00, 7'h02, 3'h4, 16'h0002);
        job(6'h00, 7'(65 + xorshift() % 63), 3'h4, 16'h0002);
        job(6'h3E, 7'h03, 3'h4, 16'h0002);
        job(6'h00, 7'h03, LAT_MIN - 3'h1, 16'h0002);
        job(6'(xorshift() % 62), 7'h03, LAT_MIN, 16'h000A);
        slow <= 1'b1;
        job(6'h3C, 7'h04, 3'h7, 16'h000A);
        slow <= 1'b0;
        no_rdy <= 1'b1;
        job(6'h00, 7'h03, 3'h5, 16'h000E);
        print_verdict();
    end
    // Seven jobs need about 52000 cycles; this leaves ample margin
    initial begin
        repeat (95000) @(posedge i_core_clk);
        failures++;
        print_verdict();
    end
endmodule // tb
